// >>> bcts_map.svh
`ifndef BCTS_MAP_SVH
`define BCTS_MAP_SVH

// Reference clock and power-system frequency
`define REF_CLK_HZ 10000000
`define SYS_FREQ_HZ 60
`define CYC_CLKS_DEFAULT (`REF_CLK_HZ / `SYS_FREQ_HZ)
`define PRESC_W 18

// Cycle timers
`define TMR_W 12
`define CF_PULSE_CYC 12'h03c
`define TF_DROP_CYC 12'h03c
`define TMR_ZERO 12'h000
`define TMR_ONE 12'h001

// Protection elements
`define ELEM_N 8
`define ELEM_NONE 8'h00

`endif

// >>> bcts_pkg.sv
package bcts_pkg;
`include "bcts_map.svh"

	typedef logic [`TMR_W-1:0] cyc_count_t;
	typedef logic [`ELEM_N-1:0] elem_vec_t;
	typedef logic [`PRESC_W-1:0] presc_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CLOSE_FAIL,
		SEL_TRIP_FAIL,
		SEL_CLOSE,
		SEL_TRIP,
		SEL_BRK_CLOSED
	} out_sel_t;

endpackage : bcts_pkg

// >>> cycle_timer.sv
`timescale 1ns/10ps
`include "bcts_map.svh"
module cycle_timer
	import bcts_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic i_tick,
	input wire cyc_count_t i_limit,
	output logic o_hit,
	output logic o_reached
);
	cyc_count_t count_ff;
	cyc_count_t nxt_count;

	// Saturates so a long run never wraps back below the limit
	always_comb
	begin
		nxt_count = count_ff;
		if (i_tick && count_ff != {`TMR_W{1'b1}})
			nxt_count = count_ff + `TMR_ONE;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset || !i_run)
			count_ff <= `TMR_ZERO;
		else
			count_ff <= nxt_count;
	end

	// Fires once, on the tick at which the count first meets a nonzero limit; a zero limit never fires
	assign o_hit = i_run && i_tick && (count_ff < i_limit) && (nxt_count >= i_limit);
	assign o_reached = i_run && (count_ff >= i_limit);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	a_timer_clear: assert property (!i_run |=> count_ff == `TMR_ZERO)
		else $error("timer not cleared while idle");
	a_timer_hit: assert property (o_hit |=> count_ff == $past(i_limit))
		else $error("timer hit at wrong count");

endmodule : cycle_timer

// >>> breaker_close_trip_supervision.sv
// Function
// - Close failure timer starts with close output
// - Close held until timer expiry or breaker closed
// - Close failure delay is configurable in cycles
// - Expiry raises close fail flag for 60 cycles
// - Close output drops when flag rises
// - Close from command or direct-close input
// - Aux input de-energized means breaker open
// - Programmable output follows a selected status bit
// - Trip when any equation element asserts
// - Trip immediately on element pickup
// - Trip failure timer starts with trip output
// - Trip held for minimum duration and requests
// - Release also needs pickups dropped or reset
// - Trip failure timer expiry raises trip fail flag
// - Trip fail flag clears 60 cycles after current
// - Not-applicable setting contributes no terms
`timescale 1ns/10ps
`include "bcts_map.svh"
module breaker_close_trip_supervision
	import bcts_pkg::*;
#(
	parameter int CYC_CLKS = `CYC_CLKS_DEFAULT
)
(
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_close_cmd,
	input wire logic i_direct_close_input,
	input wire logic i_breaker_aux_closed_input,
	input wire cyc_count_t i_close_fail_delay,
	input wire cyc_count_t i_trip_fail_delay,
	input wire cyc_count_t i_trip_min_duration,
	input wire elem_vec_t i_element_pickups,
	input wire elem_vec_t i_trip_request_equation,
	input wire elem_vec_t i_internal_torque_control,
	input wire elem_vec_t i_external_torque_control,
	input wire logic i_internal_torque_permit,
	input wire logic i_external_torque_permit,
	input wire logic i_target_reset,
	input wire out_sel_t i_output_select_four,
	output logic o_close,
	output logic o_trip,
	output logic o_close_fail_flag,
	output logic o_trip_fail_flag,
	output logic o_breaker_closed,
	output logic o_programmable_output_four
);
	presc_t presc_ff;
	logic tick_ff;
	logic close_ff;
	logic trip_ff;
	logic cf_ff;
	logic tf_ff;
	logic brk_closed_ff;
	logic prog4_ff;
	logic prog4_sel;
	elem_vec_t elem_active;
	logic trip_req;
	logic pickups_clear;
	logic close_start;
	logic trip_release;
	logic cft_hit;
	logic cf_end_hit;
	logic tft_hit;
	logic tf_drop_hit;
	logic trip_min_duration_reached;

	// One tick per power-system cycle drives every timer
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			presc_ff <= '0;
			tick_ff <= 1'b0;
		end
		else if (presc_ff == presc_t'(CYC_CLKS - 1))
		begin
			presc_ff <= '0;
			tick_ff <= 1'b1;
		end
		else
		begin
			presc_ff <= presc_ff + presc_t'(1);
			tick_ff <= 1'b0;
		end
	end

	// A torque-controlled element counts only while its permit is on.
	// An empty mask leaves the element free, so a blank entry adds no terms.
	always_comb
	begin
		elem_active = i_element_pickups;
		elem_active = elem_active & (~i_internal_torque_control |
			{`ELEM_N{i_internal_torque_permit}});
		elem_active = elem_active & (~i_external_torque_control |
			{`ELEM_N{i_external_torque_permit}});
	end

	assign trip_req = |(elem_active & i_trip_request_equation);
	assign pickups_clear = (i_element_pickups == `ELEM_NONE);

	// A close is not started onto an already closed breaker
	assign close_start = (i_close_cmd || i_direct_close_input) &&
		!i_breaker_aux_closed_input && !cf_ff;

	assign trip_release = trip_min_duration_reached && !trip_req &&
		(pickups_clear || i_target_reset);

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			brk_closed_ff <= 1'b0;
		else
			brk_closed_ff <= i_breaker_aux_closed_input;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			close_ff <= 1'b0;
		else if (close_ff && (cft_hit || i_breaker_aux_closed_input))
			close_ff <= 1'b0;
		else if (close_start)
			close_ff <= 1'b1;
	end

	cycle_timer u_close_fail_timer (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(close_ff),
		.i_tick(tick_ff),
		.i_limit(i_close_fail_delay),
		.o_hit(cft_hit),
		.o_reached()
	);

	// Flag rises on the same edge the close output falls
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			cf_ff <= 1'b0;
		else if (cft_hit)
			cf_ff <= 1'b1;
		else if (cf_end_hit)
			cf_ff <= 1'b0;
	end

	cycle_timer u_close_fail_pulse (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(cf_ff),
		.i_tick(tick_ff),
		.i_limit(`CF_PULSE_CYC),
		.o_hit(cf_end_hit),
		.o_reached()
	);

	// Latches on the first edge a request is seen; no extra qualification
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			trip_ff <= 1'b0;
		else if (trip_req)
			trip_ff <= 1'b1;
		else if (trip_ff && trip_release)
			trip_ff <= 1'b0;
	end

	cycle_timer u_trip_duration (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(trip_ff),
		.i_tick(tick_ff),
		.i_limit(i_trip_min_duration),
		.o_hit(),
		.o_reached(trip_min_duration_reached)
	);

	cycle_timer u_trip_fail_timer (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(trip_ff),
		.i_tick(tick_ff),
		.i_limit(i_trip_fail_delay),
		.o_hit(tft_hit),
		.o_reached()
	);

	// Set wins over the dropout so a fresh expiry is never lost
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			tf_ff <= 1'b0;
		else if (tft_hit)
			tf_ff <= 1'b1;
		else if (tf_drop_hit)
			tf_ff <= 1'b0;
	end

	// Current is taken as gone once every pickup has dropped out;
	// a pickup that returns restarts the dropout count
	cycle_timer u_trip_fail_drop (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(tf_ff && pickups_clear),
		.i_tick(tick_ff),
		.i_limit(`TF_DROP_CYC),
		.o_hit(tf_drop_hit),
		.o_reached()
	);

	always_comb
	begin
		case (i_output_select_four)
			SEL_NONE: prog4_sel = 1'b0;
			SEL_CLOSE_FAIL: prog4_sel = cf_ff;
			SEL_TRIP_FAIL: prog4_sel = tf_ff;
			SEL_CLOSE: prog4_sel = close_ff;
			SEL_TRIP: prog4_sel = trip_ff;
			SEL_BRK_CLOSED: prog4_sel = brk_closed_ff;
			default: prog4_sel = 1'b0;
		endcase
	end

	// Output lags its source by one clock so it comes from a flop
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			prog4_ff <= 1'b0;
		else
			prog4_ff <= prog4_sel;
	end

	assign o_close = close_ff;
	assign o_trip = trip_ff;
	assign o_close_fail_flag = cf_ff;
	assign o_trip_fail_flag = tf_ff;
	assign o_breaker_closed = brk_closed_ff;
	assign o_programmable_output_four = prog4_ff;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	a_tick_single: assert property (tick_ff |=> !tick_ff)
		else $error("tick longer than one clock");

	a_close_source: assert property ($rose(close_ff) |-> $past(close_start))
		else $error("close asserted without a request");

	a_close_hold: assert property (
		close_ff && !cft_hit && !i_breaker_aux_closed_input |=> close_ff)
		else $error("close dropped early");

	a_close_aux_drop: assert property (
		close_ff && i_breaker_aux_closed_input |=> !close_ff)
		else $error("close held after breaker closed");

	a_cf_on_expiry: assert property (
		cft_hit |=> cf_ff && !close_ff)
		else $error("close fail flag not raised with close drop");

	a_cf_pulse_hold: assert property (
		$rose(cf_ff) |-> cf_ff [*8])
		else $error("close fail flag pulse too short");

	a_cf_pulse_end: assert property (
		$fell(cf_ff) |-> $past(cf_end_hit))
		else $error("close fail flag ended without its 60-cycle timer");

	a_trip_on_req: assert property (trip_req |=> trip_ff)
		else $error("trip not asserted on request");

	a_trip_hold: assert property (
		trip_ff && (trip_req || !trip_min_duration_reached) |=> trip_ff)
		else $error("trip released too early");

	a_trip_release: assert property (
		$fell(trip_ff) |-> $past(pickups_clear || i_target_reset))
		else $error("trip released with pickups and no reset");

	a_tf_on_expiry: assert property (tft_hit |=> tf_ff)
		else $error("trip fail flag missed expiry");

	a_tf_dropout: assert property (
		$fell(tf_ff) |-> $past(tf_drop_hit))
		else $error("trip fail flag fell without dropout");

	a_na_empty: assert property (
		i_trip_request_equation == `ELEM_NONE |-> !trip_req)
		else $error("empty equation produced a trip request");

	a_breaker_open: assert property (
		!i_breaker_aux_closed_input |=> !brk_closed_ff)
		else $error("breaker shown closed with aux off");

	a_prog_follow: assert property (
		i_output_select_four == SEL_CLOSE_FAIL |=> prog4_ff == $past(cf_ff))
		else $error("output four not following close fail flag");

	a_prog_trip_fail: assert property (
		i_output_select_four == SEL_TRIP_FAIL |=> prog4_ff == $past(tf_ff))
		else $error("output four not following trip fail flag");

	a_prog_none: assert property (
		i_output_select_four == SEL_NONE |=> !prog4_ff)
		else $error("output four set with no source selected");

	a_close_take: assert property (
		close_start && !close_ff |=> close_ff)
		else $error("close request not taken");

	a_cf_blocks_close: assert property (
		cf_ff && !close_ff |=> !close_ff)
		else $error("close restarted while close fail flag high");

	a_cf_timer_run: assert property (cft_hit |-> close_ff)
		else $error("close fail timer expired with close output low");

	a_tf_timer_run: assert property (tft_hit |-> trip_ff)
		else $error("trip fail timer expired with trip output low");

	a_tf_hold: assert property (
		tf_ff && !tf_drop_hit |=> tf_ff)
		else $error("trip fail flag dropped before its dropout count");

	a_tf_drop_clear: assert property (tf_drop_hit |-> pickups_clear)
		else $error("trip fail dropout ended while current present");

	a_breaker_closed: assert property (
		i_breaker_aux_closed_input |=> brk_closed_ff)
		else $error("breaker not shown closed with aux on");

	c_close_ok: cover property ($fell(close_ff) && i_breaker_aux_closed_input);
	c_close_fail: cover property ($rose(cf_ff));
	c_trip_cycle: cover property ($rose(trip_ff) ##[1:300] $fell(trip_ff));
	c_trip_fail: cover property ($rose(tf_ff));
	c_prog_trip_fail: cover property (prog4_ff && i_output_select_four == SEL_TRIP_FAIL);

endmodule : breaker_close_trip_supervision

// >>> breaker_model.sv
`timescale 1ns/10ps
module breaker_model (
	input wire logic i_ref_clk,
	input wire logic i_close,
	input wire logic i_trip,
	input wire logic i_works,
	output logic o_aux
);
	logic [3:0] lat_ff;
	initial o_aux = 1'b0;
	initial lat_ff = 4'h0;
	// Mechanism travel takes a few clocks; a stuck breaker never moves
	always @(posedge i_ref_clk)
	begin
		lat_ff <= (i_works && i_close) ? lat_ff + 4'h1 : 4'h0;
		if (lat_ff == 4'h3)
			o_aux <= 1'b1;
		if (i_works && i_trip)
			o_aux <= 1'b0;
	end
endmodule : breaker_model

// >>> tb_breaker_close_trip_supervision.sv
`timescale 1ns/10ps
module tb_breaker_close_trip_supervision
	import bcts_pkg::*;
;
	typedef struct {elem_vec_t pk, eq, internal_torque_control, external_torque_control; logic ip, ep, exp;} row_t;
	logic i_ref_clk = 1'b0, i_reset = 1'b1, i_close_cmd = 1'b0, i_direct_close_input = 1'b0;
	logic i_breaker_aux_closed_input, i_target_reset = 1'b0, ip = 1'b0, ep = 1'b0;
	logic works = 1'b0;
	cyc_count_t cfd = 12'h003, tfd = 12'h064, tmd = 12'h000;
	elem_vec_t pk = 8'h00, eq = 8'h00, internal_torque_control = 8'h00, external_torque_control = 8'h00;
	out_sel_t sel = SEL_NONE;
	logic o_close, o_trip, o_close_fail_flag, o_trip_fail_flag, o_breaker_closed, o_four;
	int err_count = 0, n_compared = 0, n;
	row_t rows[7] = '{
		'{8'h01, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1},
		'{8'h02, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
		'{8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
		'{8'h01, 8'h01, 8'h01, 8'h00, 1'b0, 1'b0, 1'b0},
		'{8'h01, 8'h01, 8'h01, 8'h00, 1'b1, 1'b0, 1'b1},
		'{8'h04, 8'h04, 8'h00, 8'h04, 1'b0, 1'b0, 1'b0},
		'{8'h84, 8'h80, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1}};
	always #50 i_ref_clk = ~i_ref_clk;
	breaker_model brk (.i_ref_clk(i_ref_clk), .i_close(o_close), .i_trip(o_trip),
		.i_works(works), .o_aux(i_breaker_aux_closed_input));
	breaker_close_trip_supervision #(.CYC_CLKS(4)) dut (.i_ref_clk(i_ref_clk),
		.i_reset(i_reset), .i_close_cmd(i_close_cmd),
		.i_direct_close_input(i_direct_close_input),
		.i_breaker_aux_closed_input(i_breaker_aux_closed_input),
		.i_close_fail_delay(cfd), .i_trip_fail_delay(tfd), .i_trip_min_duration(tmd),
		.i_element_pickups(pk), .i_trip_request_equation(eq),
		.i_internal_torque_control(internal_torque_control), .i_external_torque_control(external_torque_control),
		.i_internal_torque_permit(ip), .i_external_torque_permit(ep),
		.i_target_reset(i_target_reset), .i_output_select_four(sel), .o_close(o_close),
		.o_trip(o_trip), .o_close_fail_flag(o_close_fail_flag),
		.o_trip_fail_flag(o_trip_fail_flag), .o_breaker_closed(o_breaker_closed),
		.o_programmable_output_four(o_four));
	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			err_count++;
		end
	endtask : chk
	task tick(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask : tick
	// Counts clocks until the signal shows the wanted level; a hang ends the run
	task automatic wt(ref logic s, input logic v, output int c);
		c = 0;
		while (s !== v)
		begin
			tick(1);
			c++;
			if (c > 2000)
			begin
				err_count++;
				end_of_test();
			end
		end
	endtask : wt
	initial
	begin
		tick(2);
		chk({o_close, o_trip, o_close_fail_flag, o_trip_fail_flag, o_four}, 0);
		i_reset = 1'b0;
		sel = SEL_TRIP;
		foreach (rows[i])
		begin
			{pk, eq, internal_torque_control, external_torque_control, ip, ep} = {rows[i].pk, rows[i].eq, rows[i].internal_torque_control,
				rows[i].external_torque_control, rows[i].ip, rows[i].ep};
			tick(3);
			chk(o_trip, rows[i].exp);
			chk(o_four, rows[i].exp);
			pk = 8'h00;
			tick(3);
			chk(o_trip, 0);
		end
		$display("trip equation table done");
		sel = SEL_CLOSE_FAIL;
		i_close_cmd = 1'b1;
		tick(1);
		i_close_cmd = 1'b0;
		wt(o_close, 1'b1, n);
		chk(n <= 1, 1);
		wt(o_close, 1'b0, n);
		chk(n >= 9 && n <= 13, 1);
		chk(o_close_fail_flag, 1);
		chk(o_breaker_closed, 0);
		tick(2);
		chk(o_four, 1);
		wt(o_close_fail_flag, 1'b0, n);
		chk(n >= 233 && n <= 242, 1);
		$display("close failure done");
		works = 1'b1;
		i_direct_close_input = 1'b1;
		wt(o_close, 1'b1, n);
		wt(o_close, 1'b0, n);
		i_direct_close_input = 1'b0;
		chk(n <= 7, 1);
		tick(16);
		chk(o_close_fail_flag, 0);
		chk(o_breaker_closed, 1);
		$display("direct close done");
		{pk, eq, tmd} = {8'h03, 8'h01, 12'h002};
		wt(o_trip, 1'b1, n);
		tick(12);
		pk = 8'h02;
		tick(8);
		chk(o_trip, 1);
		i_target_reset = 1'b1;
		wt(o_trip, 1'b0, n);
		chk(n <= 3, 1);
		{i_target_reset, pk, works, tfd} = {1'b0, 8'h00, 1'b0, 12'h005};
		tick(2);
		$display("target reset done");
		sel = SEL_TRIP_FAIL;
		pk = 8'h01;
		wt(o_trip, 1'b1, n);
		chk(n <= 2, 1);
		wt(o_trip_fail_flag, 1'b1, n);
		chk(n >= 17 && n <= 22, 1);
		chk(o_trip, 1);
		tick(1);
		chk(o_four, 1);
		pk = 8'h00;
		wt(o_trip_fail_flag, 1'b0, n);
		chk(n >= 234 && n <= 243, 1);
		$display("trip failure done");
		end_of_test();
	end
endmodule : tb_breaker_close_trip_supervision
